// file: design/ppm_pkg.sv
// Package for the parallel port mode and address block
package ppm_pkg;
    // Register offsets
    localparam logic [3:0]  MODE_OFS      = 4'h0;
    localparam logic [3:0]  ADDR_OFS      = 4'h4;
    localparam logic [3:0]  DATA_OFS      = 4'h8;
    localparam logic [3:0]  CTRL_OFS      = 4'hc;
    // Mode and control register field positions
    localparam int          BUSY_BIT      = 15;
    localparam int          IRQ_LSB       = 13;
    localparam int          STEP_LSB      = 11;
    localparam int          WIDE_BIT      = 10;
    localparam int          PMODE_LSB     = 8;
    localparam int          SETUP_LSB     = 6;
    localparam int          STROBE_LSB    = 2;
    localparam int          END_LSB       = 0;
    localparam int          CSF_LSB       = 6;
    // Reset values
    localparam logic [14:0] MODE_RST      = 15'h0000;
    localparam logic [15:0] ADDR_RST      = 16'h0000;
    localparam logic [1:0]  CSF_RST       = 2'h0;
    // Codes
    localparam logic [1:0]  IRQ_NONE      = 2'h0;
    localparam logic [1:0]  IRQ_EACH      = 2'h1;
    localparam logic [1:0]  IRQ_FOURTH    = 2'h2;
    localparam logic [1:0]  STEP_UP       = 2'h1;
    localparam logic [1:0]  STEP_DOWN     = 2'h2;
    localparam logic [1:0]  STEP_BUF      = 2'h3;
    localparam logic [1:0]  PM_LEGACY     = 2'h0;
    localparam logic [1:0]  PM_ADDRSLV    = 2'h1;
    localparam logic [1:0]  PM_MASTER2    = 2'h2;
    localparam logic [1:0]  PM_MASTER1    = 2'h3;
    localparam logic [1:0]  CSF_BOTH      = 2'h2;
    localparam logic [1:0]  CSF_TWO       = 2'h1;

    // Master cycle phases
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_END    = 4'b1000
    } ppm_state_e;

    // Register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ppm_req_s;

    // Master pins
    typedef struct packed {
        logic [1:0]  sel;
        logic [13:0] addr;
        logic        rd;
        logic        wr;
        logic        en;
    } ppm_mpins_s;
endpackage

// file: design/ppm_port.sv
// Parallel port mode, address, master cycle and slave port logic
// Notes on behaviour
// - Master modes: mode bit 15 reads 1 while a transfer runs.
// - Code 10: interrupt on fourth buffer, or slave address 11.
// - Code 01: interrupt at end of every port cycle.
// - Code 00: no interrupt; software never writes code 11.
// - Step code 11 advances slave buffer pointers, legacy slave only.
// - Step code 10 decrements address after every cycle.
// - Step code 01 increments; code 00 leaves address alone.
// - Wide bit selects one 16-bit or one 8-bit transfer.
// - Mode 11: master with direction line and strobe enable.
// - Mode 10: master with separate read and write strobes.
// - Mode 01: slave with select, strobes, 8 data, 2 address lines.
// - Mode 00: slave with select, strobes, 8 data, no address.
// - Setup wait field gives one to four clock periods.
// - Strobe wait 0000: write one period; read setup one, end zero; writes also get setup one, end zero.
// - Address bits used as selects are not stepped.
// - Upper data pins driven and sampled only in wide mode.
// - Bit 15 is select two when field is 10 or 01.
// - Bit 14 is select one only when field is 10.
// - Bits 13 to 0 always drive the address pins.
// - Upper sixteen bits of mode and address read zero.
`timescale 1ns/1ps
`default_nettype none
module ppm_port
    import ppm_pkg::*;
(
    input  wire logic                CLOCK,
    input  wire logic                RESET_N,
    input  wire ppm_pkg::ppm_req_s   REQ,
    output logic [31:0]              RDATA,
    output ppm_pkg::ppm_mpins_s      MPINS,
    output logic                     MASTER_OE,
    input  wire logic [15:0]         PD_IN,
    output logic [15:0]              PD_OUT,
    output logic [15:0]              PD_OE,
    input  wire logic                S_SEL_N,
    input  wire logic                S_RD_N,
    input  wire logic                S_WR_N,
    input  wire logic [1:0]          S_ADDR,
    output logic                     IRQ
);
    import ppm_pkg::*;

    logic [14:0] mode;
    logic [15:0] addr;
    logic [1:0]  select_function_field;
    logic        busy;
    ppm_state_e  state;
    logic [3:0]  cnt;
    logic        is_read;
    logic [15:0] wdat;
    logic [15:0] rdat;
    logic [7:0]  sbuf_in [4];
    logic [7:0]  sbuf_out [4];
    logic [1:0]  rptr;
    logic [1:0]  wptr;
    logic [2:0]  sel_q1, sel_q2, sel_q3;
    logic [1:0]  sa_q1, sa_q2;
    logic [15:0] pd_q1, pd_q2;
    logic        m_done;
    logic        s_rd_ev, s_wr_ev;

    wire logic [1:0] irq_sel = mode[IRQ_LSB+1:IRQ_LSB];
    wire logic [1:0] step    = mode[STEP_LSB+1:STEP_LSB];
    wire logic       wide    = mode[WIDE_BIT];
    wire logic [1:0] pmode   = mode[PMODE_LSB+1:PMODE_LSB];
    wire logic [1:0] setup_w = mode[SETUP_LSB+1:SETUP_LSB];
    wire logic [3:0] strb_w  = mode[STROBE_LSB+3:STROBE_LSB];
    wire logic [1:0] end_w   = mode[END_LSB+1:END_LSB];
    wire logic       master  = pmode[1];
    wire logic       dat_acc = master && (REQ.wr || REQ.rd) && REQ.addr == DATA_OFS && !busy;

    // Top address bits that act as selects are held out of stepping
    function automatic logic [15:0] step_mask(input logic [1:0] f);
        logic [15:0] m;
        m = 16'hffff;
        if (f == CSF_BOTH)
            m = 16'h3fff;
        else if (f == CSF_TWO)
            m = 16'h7fff;
        return m;
    endfunction

    // Register writes; address also stepped by the master engine
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode <= MODE_RST;
            addr <= ADDR_RST;
            select_function_field  <= CSF_RST;
        end else begin
            if (REQ.wr && REQ.addr == MODE_OFS)
                mode <= REQ.wdata[14:0];
            if (REQ.wr && REQ.addr == CTRL_OFS)
                select_function_field <= REQ.wdata[CSF_LSB+1:CSF_LSB];
            if (REQ.wr && REQ.addr == ADDR_OFS) begin
                addr <= REQ.wdata[15:0];
            end else if (m_done) begin
                unique case (step)
                    STEP_UP:   addr <= (addr & ~step_mask(select_function_field)) | ((addr + 16'h0001) & step_mask(select_function_field));
                    STEP_DOWN: addr <= (addr & ~step_mask(select_function_field)) | ((addr - 16'h0001) & step_mask(select_function_field));
                    default:   addr <= addr;
                endcase
            end
        end
    end

    // Master cycle sequencer, counts are in clock periods
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            state   <= ST_IDLE;
            cnt     <= 4'h0;
            busy    <= 1'b0;
            is_read <= 1'b0;
            wdat    <= 16'h0000;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (dat_acc) begin
                        busy    <= 1'b1;
                        is_read <= REQ.rd;
                        wdat    <= REQ.wdata[15:0];
                        state   <= ST_SETUP;
                        cnt     <= (strb_w == 4'h0) ? 4'h0 : {2'b00, setup_w};
                    end
                end
                ST_SETUP: begin
                    if (cnt == 4'h0) begin
                        state <= ST_STROBE;
                        cnt   <= (strb_w == 4'h0) ? 4'h0 : strb_w - 4'h1;
                    end else
                        cnt <= cnt - 4'h1;
                end
                ST_STROBE: begin
                    if (cnt == 4'h0) begin
                        if (strb_w == 4'h0 || end_w == 2'h0) begin
                            state <= ST_IDLE;
                            busy  <= 1'b0;
                        end else begin
                            state <= ST_END;
                            cnt   <= {2'b00, end_w} - 4'h1;
                        end
                    end else
                        cnt <= cnt - 4'h1;
                end
                ST_END: begin
                    if (cnt == 4'h0) begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                    end else
                        cnt <= cnt - 4'h1;
                end
            endcase
        end
    end

    assign m_done = (state == ST_STROBE && cnt == 4'h0 && (strb_w == 4'h0 || end_w == 2'h0))
                 || (state == ST_END && cnt == 4'h0);

    // Pin synchronisers; slave strobes are asynchronous to the clock
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            sel_q1 <= 3'h7;
            sel_q2 <= 3'h7;
            sel_q3 <= 3'h7;
            sa_q1  <= 2'h0;
            sa_q2  <= 2'h0;
            pd_q1  <= 16'h0000;
            pd_q2  <= 16'h0000;
        end else begin
            sel_q1 <= {S_SEL_N, S_RD_N, S_WR_N};
            sel_q2 <= sel_q1;
            sel_q3 <= sel_q2;
            sa_q1  <= S_ADDR;
            sa_q2  <= sa_q1;
            pd_q1  <= PD_IN;
            pd_q2  <= pd_q1;
        end
    end

    // Access ends on strobe rise while selected
    assign s_rd_ev = !master && !sel_q3[2] && !sel_q3[1] && sel_q2[1];
    assign s_wr_ev = !master && !sel_q3[2] && !sel_q3[0] && sel_q2[0];

    // slave buffers, addressed or pointer driven
    wire logic [1:0] widx = (pmode == PM_ADDRSLV) ? sa_q2 : wptr;
    wire logic [1:0] ridx = (pmode == PM_ADDRSLV) ? sa_q2 : rptr;
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rptr <= 2'h0;
            wptr <= 2'h0;
            for (int i = 0; i < 4; i++) begin
                sbuf_in[i]  <= 8'h00;
                sbuf_out[i] <= 8'h00;
            end
        end else begin
            if (s_wr_ev)
                sbuf_in[widx] <= pd_q2[7:0];
            if (!master && REQ.wr && REQ.addr == DATA_OFS)
                sbuf_out[REQ.wdata[9:8]] <= REQ.wdata[7:0];
            if (pmode == PM_LEGACY && step == STEP_BUF) begin
                if (s_wr_ev)
                    wptr <= wptr + 2'h1;
                if (s_rd_ev)
                    rptr <= rptr + 2'h1;
            end
        end
    end

    // Read capture at cycle end, after any end wait
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N)
            rdat <= 16'h0000;
        else if (m_done && is_read)
            // upper lane sampled only when wide
            rdat <= wide ? pd_q2 : {8'h00, pd_q2[7:0]};
    end

    // Interrupt pulse selection
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N)
            IRQ <= 1'b0;
        else begin
            unique case (irq_sel)
                IRQ_EACH:   IRQ <= m_done || s_rd_ev || s_wr_ev;
                IRQ_FOURTH: IRQ <= (pmode == PM_ADDRSLV) ? ((s_rd_ev || s_wr_ev) && sa_q2 == 2'h3)
                                 : ((s_rd_ev && rptr == 2'h3) || (s_wr_ev && wptr == 2'h3));
                default:    IRQ <= 1'b0;
            endcase
        end
    end

    // Register read data, one cycle after strobe
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N)
            RDATA <= 32'h0000_0000;
        else if (REQ.rd) begin
            unique case (REQ.addr)
                MODE_OFS: RDATA <= {16'h0000, busy && master, mode};
                ADDR_OFS: RDATA <= {16'h0000, addr};
                DATA_OFS: RDATA <= master ? {16'h0000, rdat} : {24'h000000, sbuf_in[ridx]};
                CTRL_OFS: RDATA <= {24'h000000, select_function_field, 6'h00};
                default:  RDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Master pin drive; selects and strobes are active high here
    wire logic in_strobe = state == ST_STROBE;
    always_comb begin
        MASTER_OE   = master;
        MPINS.addr  = addr[13:0];
        MPINS.sel   = {(select_function_field == CSF_BOTH || select_function_field == CSF_TWO) && addr[15], select_function_field == CSF_BOTH && addr[14]};
        if (pmode == PM_MASTER1) begin
            MPINS.rd = busy && is_read;
            MPINS.wr = 1'b0;
            MPINS.en = in_strobe;
        end else begin
            MPINS.rd = in_strobe && is_read;
            MPINS.wr = in_strobe && !is_read;
            MPINS.en = 1'b0;
        end
        PD_OUT = master ? wdat : {8'h00, sbuf_out[ridx]};
        PD_OE  = 16'h0000;
        if (master && busy && !is_read)
            PD_OE = wide ? 16'hffff : 16'h00ff;
        else if (!master && !sel_q2[2] && !sel_q2[1])
            PD_OE = 16'h00ff;
    end

    // Checks
    a_busy_bit: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        REQ.rd && REQ.addr == MODE_OFS |=> RDATA[BUSY_BIT] == $past(busy && master))
        else $error("busy bit wrong");
    a_busy_start: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        dat_acc |=> busy)
        else $error("busy not set");
    a_fast_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        dat_acc && REQ.wr && strb_w == 4'h0 |=> ##2 !busy)
        else $error("short cycle length wrong");
    a_upper_zero: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        REQ.rd && (REQ.addr == MODE_OFS || REQ.addr == ADDR_OFS) |=> RDATA[31:16] == 16'h0000)
        else $error("upper half not zero");
    a_step_up: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        m_done && step == STEP_UP && select_function_field == 2'h0 && !REQ.wr |=> addr == $past(addr) + 16'h0001)
        else $error("increment wrong");
    a_step_down: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        m_done && step == STEP_DOWN && select_function_field == 2'h0 && !REQ.wr |=> addr == $past(addr) - 16'h0001)
        else $error("decrement wrong");
    a_sel_keep: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        m_done && select_function_field == CSF_BOTH && !REQ.wr |=> addr[15:14] == $past(addr[15:14]))
        else $error("select bits stepped");
    a_narrow_pins: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !wide |-> PD_OE[15:8] == 8'h00)
        else $error("upper lane driven");
    a_irq_none: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        irq_sel == IRQ_NONE |=> !IRQ)
        else $error("irq in mode none");
    a_irq_each: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        irq_sel == IRQ_EACH && m_done |=> IRQ)
        else $error("irq missing");
    c_master_rd: cover property (@(posedge CLOCK) disable iff (!RESET_N) dat_acc && REQ.rd);
    c_master_wr: cover property (@(posedge CLOCK) disable iff (!RESET_N) dat_acc && REQ.wr);
    c_slave_wr:  cover property (@(posedge CLOCK) disable iff (!RESET_N) s_wr_ev);
    c_irq4:      cover property (@(posedge CLOCK) disable iff (!RESET_N) irq_sel == IRQ_FOURTH && IRQ);
    c_legacy_rd: cover property (@(posedge CLOCK) disable iff (!RESET_N) s_rd_ev && pmode == PM_LEGACY);

    // Cycle shape, pin use and slave buffers; mode is assumed steady within a cycle
    a_setup_four: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(busy) && strb_w != 4'h0 && setup_w == 2'h3 |-> !in_strobe [*4] ##1 in_strobe)
        else $error("setup of four wrong");
    a_setup_one: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(busy) && strb_w != 4'h0 && setup_w == 2'h0 |-> !in_strobe ##1 in_strobe)
        else $error("setup of one wrong");
    a_idle_strobes: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !busy |-> !MPINS.rd && !MPINS.wr && !MPINS.en)
        else $error("strobe outside cycle");
    a_dir_steady: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        pmode == PM_MASTER1 && busy && $past(busy) && $stable(mode) |-> $stable(MPINS.rd))
        else $error("direction line moved");
    a_sep_strobes: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        pmode == PM_MASTER2 |-> !MPINS.en)
        else $error("enable used in mode 10");
    a_wide_drive: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        master && busy && !is_read && wide |-> PD_OE == 16'hffff)
        else $error("wide write not driven");
    a_narrow_read: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        m_done && is_read && !wide |=> rdat[15:8] == 8'h00)
        else $error("upper lane sampled");
    a_no_sel: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        select_function_field == 2'h0 |-> MPINS.sel == 2'h0)
        else $error("select without field");
    a_sel_one: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        select_function_field != CSF_BOTH |-> !MPINS.sel[0])
        else $error("select one misused");
    a_addr_held: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        busy && !(REQ.wr && REQ.addr == ADDR_OFS) |=> $stable(addr) || !busy)
        else $error("address moved mid cycle");
    a_busy_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        m_done |=> !busy)
        else $error("busy not cleared");
    a_ptr_step: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        s_wr_ev && pmode == PM_LEGACY && step == STEP_BUF |=> wptr == $past(wptr) + 2'h1)
        else $error("write pointer not stepped");
    a_ptr_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        pmode != PM_LEGACY |=> $stable(rptr) && $stable(wptr))
        else $error("pointer moved outside legacy");
    a_irq_addr: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        irq_sel == IRQ_FOURTH && pmode == PM_ADDRSLV && s_wr_ev && sa_q2 == 2'h3 |=> IRQ)
        else $error("address irq missing");
    a_irq_legacy: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        irq_sel == IRQ_FOURTH && pmode == PM_LEGACY && s_wr_ev && wptr == 2'h3 |=> IRQ)
        else $error("fourth buffer irq missing");
    a_slave_lane: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !master |-> PD_OE[15:8] == 8'h00)
        else $error("slave drives upper lane");
endmodule
`default_nettype wire

// file: testbench/ppm_periph.sv
// Far-side peripheral model answering the master port
`timescale 1ns/1ps
`default_nettype none
module ppm_periph
    import ppm_pkg::*;
(
    input  wire logic                CLOCK,
    input  wire ppm_pkg::ppm_mpins_s MPINS,
    input  wire logic                COMBINED,
    input  wire logic [15:0]         PD_OUT,
    input  wire logic [15:0]         PD_OE,
    output logic [15:0]              PD,
    output logic [15:0]              WDATA
);
    logic       rd_stb;
    logic       wr_stb;
    logic [2:0] hold;
    assign rd_stb = COMBINED ? (MPINS.en & MPINS.rd) : MPINS.rd;
    assign wr_stb = COMBINED ? (MPINS.en & ~MPINS.rd) : MPINS.wr;
    // Data held briefly past the strobe, then scrambled so stale data never passes
    always @(posedge CLOCK) begin
        if (rd_stb) begin
            PD <= {~MPINS.addr[7:0], MPINS.addr[7:0]};
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end else begin
            PD <= ~PD + 16'h1357;
        end
        if (wr_stb) begin
            WDATA <= PD_OUT & PD_OE;
        end
    end
    initial begin
        PD = 16'h0;
        hold = 3'h0;
        WDATA = 16'h0;
    end
endmodule
`default_nettype wire

// file: testbench/parallel_port_mode_address_tb.sv
// Self-checking bench for the parallel port mode and address block
`timescale 1ns/1ps
`default_nettype none
module parallel_port_mode_address_tb;
    import ppm_pkg::*;
    logic CLOCK, RESET_N, moe, irq, combined, host_on, s_sel_n, s_rd_n, s_wr_n, stb_d, oe_hi, first;
    ppm_req_s req;
    ppm_mpins_s mp;
    logic [31:0] rdata, v, r;
    logic [15:0] pd_in, pd_out, pd_oe, periph_pd, periph_w, host_pd, a0, a1, m, d;
    logic [1:0]  s_addr, select_function_field, st, irqc, su;
    logic [3:0]  sw;
    logic [14:0] md;
    logic [15:0] a_seen;
    int num_errors, comparisons, cyc, t0, gap, stb_len, irqs, i0;
    wire stb = combined ? mp.en : (mp.wr | mp.rd);
    assign pd_in = host_on ? host_pd : periph_pd;
    ppm_port u_ppm_port (.CLOCK(CLOCK), .RESET_N(RESET_N), .REQ(req), .RDATA(rdata), .MPINS(mp),
        .MASTER_OE(moe), .PD_IN(pd_in), .PD_OUT(pd_out), .PD_OE(pd_oe), .S_SEL_N(s_sel_n),
        .S_RD_N(s_rd_n), .S_WR_N(s_wr_n), .S_ADDR(s_addr), .IRQ(irq));
    ppm_periph u_ppm_periph (.CLOCK(CLOCK), .MPINS(mp), .COMBINED(combined), .PD_OUT(pd_out),
        .PD_OE(pd_oe), .PD(periph_pd), .WDATA(periph_w));
    // Clock of 25 ns
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    // Cycle count and hang limit
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    // Pin monitor, sampled mid-cycle where outputs have settled
    always @(negedge CLOCK) begin
        if ((req.wr | req.rd) && req.addr == DATA_OFS) begin
            t0 = cyc;
            stb_len = 0;
            oe_hi = 1'b0;
        end
        if (stb && !stb_d) begin
            gap = cyc - t0;
            a_seen = {mp.sel, mp.addr};
        end
        if (stb) stb_len++;
        if (pd_oe[15:8] != 8'h0) oe_hi = 1'b1;
        if (irq === 1'b1) irqs++;
        stb_d = stb;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] dat);
        req <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
        @(posedge CLOCK);
        req.wr <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic rreg(input logic [3:0] a, output logic [31:0] q);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge CLOCK);
        req.rd <= 1'b0;
        @(negedge CLOCK);
        q = rdata;
        @(posedge CLOCK);
    endtask
    // Polls the mode register until the port is idle, bounded
    task automatic settle(output logic b);
        logic [31:0] q;
        rreg(MODE_OFS, q);
        b = q[BUSY_BIT];
        for (int k = 0; k < 20 && q[BUSY_BIT] !== 1'b0; k++) rreg(MODE_OFS, q);
        chk("busy clear", 32'h0, {31'h0, q[BUSY_BIT]});
        repeat (3) @(posedge CLOCK);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        req = '0;
        RESET_N = 1'b0;
        {combined, host_on, stb_d, oe_hi} = 4'h0;
        {s_sel_n, s_rd_n, s_wr_n} = 3'h7;
        s_addr = 2'h0;
        host_pd = 16'h0;
        {num_errors, comparisons, cyc, t0, gap, stb_len, irqs} = '0;
        r = $urandom(36703);
        repeat (12) @(posedge CLOCK);
        RESET_N <= 1'b1;
        @(posedge CLOCK);
        rreg(MODE_OFS, v);
        chk("mode reset", 32'h0, v);
        rreg(ADDR_OFS, v);
        chk("addr reset", 32'h0, v);
        rreg(4'h2, v);
        chk("unmapped", 32'h0, v);
        $display("test reset done");
        // Master writes: step codes, select fields, widths, wait fields, irq codes
        for (int i = 0; i < 6; i++) begin
            r = $urandom;
            case (i)
                0: begin select_function_field = 2'h0; st = 2'h1; a0 = r[15:0]; end
                1: begin select_function_field = 2'h0; st = 2'h2; a0 = 16'h0000; end
                2: begin select_function_field = 2'h0; st = 2'h0; a0 = r[15:0]; end
                3: begin select_function_field = 2'h2; st = 2'h1; a0 = 16'hffff; end
                4: begin select_function_field = 2'h1; st = 2'h1; a0 = 16'hbfff; end
                default: begin select_function_field = 2'h2; st = 2'h2; a0 = 16'h8000; end
            endcase
            i0 = i;
            irqc = 2'(i0 % 3);
            sw = 4'((i0 * 3) % 16);
            su = 2'(i0 % 4);
            combined <= (i > 2);
            md = {irqc, st, i0[0], (i > 2) ? PM_MASTER1 : PM_MASTER2, su, sw, su};
            d = r[31:16];
            m = (select_function_field == 2'h2) ? 16'h3fff : (select_function_field == 2'h1) ? 16'h7fff : 16'hffff;
            a1 = (a0 & ~m) | ((a0 + ((st == 2'h1) ? 16'h1 : (st == 2'h2) ? 16'hffff : 16'h0)) & m);
            wreg(CTRL_OFS, {24'h0, select_function_field, 6'h0});
            wreg(MODE_OFS, {16'hffff, 1'b1, md});
            wreg(ADDR_OFS, {16'hffff, a0});
            rreg(MODE_OFS, v);
            chk("mode readback", {17'h0, md}, v);
            irqs = 0;
            wreg(DATA_OFS, {16'h0, d});
            settle(first);
            chk("busy seen", 32'h1, {31'h0, first});
            rreg(ADDR_OFS, v);
            chk("addr stepped", {16'h0, a1}, v);
            chk("pins at strobe", {16'h0, select_function_field != 2'h0 && a0[15], select_function_field == 2'h2 && a0[14], a0[13:0]}, {16'h0, a_seen});
            chk("setup gap", (sw == 4'h0) ? 2 : su + 2, gap);
            chk("strobe length", (sw == 4'h0) ? 1 : sw, stb_len);
            chk("written data", i0[0] ? d : {8'h0, d[7:0]}, periph_w);
            chk("upper drive", i0[0], oe_hi);
            chk("irq count", (irqc == IRQ_EACH) ? 1 : 0, irqs);
            chk("master enable", 32'h1, {31'h0, moe});
        end
        $display("test master write done");
        // Master reads in both master modes and widths
        for (int j = 0; j < 2; j++) begin
            r = $urandom;
            combined <= (j == 1);
            wreg(MODE_OFS, {17'h0, 2'h0, 2'h0, j[0], (j == 1) ? PM_MASTER1 : PM_MASTER2, 2'h1, 4'h2, 2'h3});
            wreg(ADDR_OFS, {16'h0, r[15:0]});
            rreg(DATA_OFS, v);
            settle(first);
            rreg(DATA_OFS, v);
            chk("read data", {16'h0, j[0] ? ~r[7:0] : 8'h0, r[7:0]}, v);
            settle(first);
        end
        $display("test master read done");
        // Addressed slave: irq on address 11 only with code 10, none with code 00
        combined <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            wreg(MODE_OFS, {17'h0, (k == 2) ? IRQ_NONE : IRQ_FOURTH, 2'h0, 1'b0, PM_ADDRSLV, 8'h0});
            irqs = 0;
            r = $urandom;
            host_on <= 1'b1;
            host_pd <= r[15:0];
            s_addr <= (k == 1) ? 2'h1 : 2'h3;
            s_sel_n <= 1'b0;
            repeat (2) @(posedge CLOCK);
            s_wr_n <= 1'b0;
            repeat (3) @(posedge CLOCK);
            s_wr_n <= 1'b1;
            repeat (2) @(posedge CLOCK);
            s_sel_n <= 1'b1;
            host_on <= 1'b0;
            repeat (8) @(posedge CLOCK);
            chk("slave irq", (k == 0) ? 1 : 0, irqs);
            chk("slave enable", 32'h0, {31'h0, moe});
            rreg(DATA_OFS, v);
            chk("slave byte", {24'h0, r[7:0]}, v);
        end
        $display("test slave done");
        // Legacy slave, stepped buffers: fourth host write interrupts, host read steps
        wreg(MODE_OFS, {17'h0, IRQ_FOURTH, STEP_BUF, 1'b0, PM_LEGACY, 8'h0});
        r = $urandom;
        wreg(DATA_OFS, {24'h0, r[15:8]});
        irqs = 0;
        host_on <= 1'b1;
        s_sel_n <= 1'b0;
        for (int n = 0; n < 5; n++) begin
            host_pd <= {8'h0, r[7:0] + 8'(n)};
            s_wr_n <= (n == 4);
            s_rd_n <= (n != 4);
            repeat (3) @(posedge CLOCK);
            @(negedge CLOCK);
            if (n == 4)
                chk("slave out byte", {24'h0, r[15:8]}, {16'h0, pd_out & pd_oe});
            @(posedge CLOCK);
            {s_wr_n, s_rd_n} <= 2'h3;
            repeat (3) @(posedge CLOCK);
        end
        s_sel_n <= 1'b1;
        host_on <= 1'b0;
        chk("legacy irq", 32'h1, irqs);
        rreg(DATA_OFS, v);
        chk("legacy pointer", {24'h0, r[7:0] + 8'h01}, v);
        $display("test legacy slave done");
        wrap_up();
    end
endmodule
`default_nettype wire
